// ### logic/cmm_pkg.sv
// Package: constants, opcodes and register map of the code memory modify sequencer
// Function
// (RULE_01) Plain write sequences assume the programmer bulk erased the array first.
// (RULE_02) Programmer reads one erase block back and modifies it in its own buffer.
// (RULE_03) That block is then erased in the device and fully reprogrammed.
// (RULE_04) Cycle-go starts a write or erase only when program-unlock is already set.
// (RULE_05) Code memory is selected by two core instructions on the control register.
// (RULE_06) Table pointer loads upper, high, low bytes via literal move then register move.
// (RULE_07) Unlock then row-erase select before erase; unlock cleared after all writes.
// (RULE_08) Cycle-go starts erase; following no-op holds clock high, then low.
// (RULE_09) Command 1101 stores two payload bytes, then advances table pointer by two.
// (RULE_10) Buffer bytes land at positions chosen by the current table pointer.
// (RULE_11) Programmer repeats the two-byte load, holding back the last two bytes.
// (RULE_12) Command 1111 stores the last two bytes and starts programming.
// (RULE_13) After the start command the programmer sends a no-op with timed clock.
// (RULE_14) Programmer repeats read, erase, reload per block, stepping the block address.
// (RULE_15) Programmer repeats load and program until the erased block is rewritten.
// (RULE_16) Programming runs while the fourth clock pulse of the no-op stays high.
// (RULE_17) Programmer keeps the clock low for the discharge time after the cycle.
// (RULE_18) Command 0000 executes its payload as one core instruction.
package cmm_pkg;
    localparam logic [31:0] OFS_CTRL = 32'h00000000;
    localparam logic [31:0] OFS_STATUS = 32'h00000004;
    localparam logic [31:0] OFS_TBLPTR = 32'h00000008;
    localparam logic [31:0] OFS_WREG = 32'h0000000C;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RST = 1'h1;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_REFUSED_BIT = 9;
    localparam logic [7:0] NVM_CTRL_RST = 8'h00;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam int NVM_MEM_SEL_BIT = 7;
    localparam int NVM_CFG_SEL_BIT = 6;
    localparam int NVM_ROW_ERASE_BIT = 4;
    localparam int NVM_UNLOCK_BIT = 2;
    localparam logic [2:0] NVM_GO_BIT = 3'h1;
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_LOAD = 4'hD;
    localparam logic [3:0] CMD_START = 4'hF;
    localparam logic [7:0] OP_MOVLW = 8'h0E;
    localparam logic [7:0] OP_MOVWF = 8'h6E;
    localparam logic [3:0] OP_BSF = 4'h8;
    localparam logic [3:0] OP_BCF = 4'h9;
    localparam logic [7:0] SFR_NVM_CTRL = 8'hA6;
    localparam logic [7:0] SFR_PTR_UPPER = 8'hF8;
    localparam logic [7:0] SFR_PTR_HIGH = 8'hF7;
    localparam logic [7:0] SFR_PTR_LOW = 8'hF6;
    localparam int PTR_W = 22;
    localparam logic [21:0] PTR_RST = 22'h000000;
    localparam logic [21:0] PTR_STEP = 22'h000002;
    localparam int WBUF_BYTES = 64;
    localparam int WBUF_IDX_W = 6;
    localparam logic [4:0] FRAME_LAST = 5'h13;
    localparam logic [4:0] HOLD_CNT = 5'h03;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} cmm_state_t;

    function automatic logic [7:0] cmm_bit_mask(input logic [2:0] pos);
        cmm_bit_mask = 8'h01 << pos;
    endfunction : cmm_bit_mask
endpackage : cmm_pkg

// ### logic/cmm_link_if.sv
// Interface: frame words and hold level from the serial link shifter
`timescale 1ns/1ns
interface cmm_link_if;
    logic toggle;
    logic hold;
    logic [3:0] cmd;
    logic [15:0] payload;
    modport shifter (output toggle, output hold, output cmd, output payload);
    modport seq (input toggle, input hold, input cmd, input payload);
endinterface : cmm_link_if

// ### logic/cmm_shift.sv
// Module: serial link shifter on the programmer's clock
`timescale 1ns/1ns
module cmm_shift (
    input wire logic hresetn,
    input wire logic prog_serial_clock,
    input wire logic data_in,
    cmm_link_if.shifter lk
);
    logic [4:0] bit_cnt;
    logic [19:0] shreg;

    // Bits arrive least significant first: command, then payload
    wire [19:0] next_shreg = {data_in, shreg[19:1]};
    wire frame_end = (bit_cnt == cmm_pkg::FRAME_LAST);
    wire [4:0] next_cnt = frame_end ? 5'h00 : bit_cnt + 5'h01;

    always_ff @(posedge prog_serial_clock or negedge hresetn)
    begin
        if (!hresetn)
        begin
            shreg <= 20'h00000;
            bit_cnt <= 5'h00;
            lk.hold <= 1'h0;
            lk.cmd <= 4'h0;
            lk.payload <= 16'h0000;
            lk.toggle <= 1'h0;
        end
        else
        begin
            shreg <= next_shreg;
            bit_cnt <= next_cnt;
            // High from the fourth rising edge until the fifth
            lk.hold <= (bit_cnt == cmm_pkg::HOLD_CNT); // RULE_16
            if (frame_end)
            begin
                // Word held stable until the next frame; toggle marks it
                lk.cmd <= next_shreg[3:0];
                lk.payload <= next_shreg[19:4];
                lk.toggle <= ~lk.toggle;
            end
        end
    end
endmodule : cmm_shift

// ### logic/cmm_seq.sv
// Module: code memory modify sequencer top with AHB-Lite register slave
`timescale 1ns/1ns
module cmm_seq (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data_in,
    output logic prog_serial_data_out,
    output logic prog_serial_data_oe,
    output logic flash_erase,
    output logic flash_program,
    output logic [21:0] flash_addr,
    input wire logic [5:0] flash_buf_raddr,
    output logic [7:0] flash_buf_rdata
);
    cmm_link_if lk ();

    cmm_shift u_shift (
        .hresetn(hresetn),
        .prog_serial_clock(prog_serial_clock),
        .data_in(prog_serial_data_in),
        .lk(lk.shifter)
    );

    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic hold_s1;
    logic hold_s2;
    logic sclk_s1;
    logic sclk_s2;
    logic enable;
    logic refused;
    logic [7:0] nvm_control_reg;
    logic [7:0] w_reg;
    logic [21:0] tblptr;
    logic op_erase;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [7:0] wbuf [cmm_pkg::WBUF_BYTES];
    cmm_pkg::cmm_state_t state;
    cmm_pkg::cmm_state_t next_state;

    // Link crossings: toggle for words, two flops for levels
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tgl_s1 <= 1'h0;
            tgl_s2 <= 1'h0;
            tgl_s3 <= 1'h0;
            hold_s1 <= 1'h0;
            hold_s2 <= 1'h0;
            sclk_s1 <= 1'h0;
            sclk_s2 <= 1'h0;
        end
        else
        begin
            tgl_s1 <= lk.toggle;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
            hold_s1 <= lk.hold;
            hold_s2 <= hold_s1;
            sclk_s1 <= prog_serial_clock;
            sclk_s2 <= sclk_s1;
        end
    end

    // Frame decode; the word is stable for many cycles after its toggle
    wire frame_new = tgl_s2 ^ tgl_s3;
    wire exec = frame_new && enable;
    wire [3:0] cmd = lk.cmd;
    wire [7:0] pay_hi = lk.payload[15:8];
    wire [7:0] pay_lo = lk.payload[7:0];
    wire is_core = exec && (cmd == cmm_pkg::CMD_CORE);
    wire is_load = exec && (cmd == cmm_pkg::CMD_LOAD);
    wire is_start = exec && (cmd == cmm_pkg::CMD_START);
    wire is_movlw = is_core && (pay_hi == cmm_pkg::OP_MOVLW);
    wire is_movwf = is_core && (pay_hi == cmm_pkg::OP_MOVWF);
    wire is_bsf = pay_hi[7:4] == cmm_pkg::OP_BSF;
    wire is_bcf = pay_hi[7:4] == cmm_pkg::OP_BCF;
    wire is_bitop = is_core && (pay_lo == cmm_pkg::SFR_NVM_CTRL) && (is_bsf || is_bcf);
    wire [7:0] bit_mask = cmm_pkg::cmm_bit_mask(pay_hi[3:1]);
    wire [7:0] go_mask = cmm_pkg::cmm_bit_mask(cmm_pkg::NVM_GO_BIT);
    wire set_go = is_bitop && is_bsf && (pay_hi[3:1] == cmm_pkg::NVM_GO_BIT);
    wire unlocked = nvm_control_reg[cmm_pkg::NVM_UNLOCK_BIT];
    wire idle = (state == cmm_pkg::ST_IDLE);
    wire go_ok = set_go && unlocked && idle; // RULE_04
    wire go_refused = set_go && !go_ok; // RULE_04
    wire run_start = go_ok || (is_start && idle); // RULE_12
    wire run_done = (state == cmm_pkg::ST_RUN) && !sclk_s2;
    wire buf_fill = is_load || is_start;
    wire [5:0] idx_even = {tblptr[cmm_pkg::WBUF_IDX_W-1:1], 1'h0};
    wire [5:0] idx_odd = {tblptr[cmm_pkg::WBUF_IDX_W-1:1], 1'h1};

    // Bit set and clear on the control register; go bit owned by hardware
    wire [7:0] bit_applied = is_bsf ? (nvm_control_reg | bit_mask)
                                    : (nvm_control_reg & ~bit_mask);
    wire [7:0] nvm_soft = is_bitop ? bit_applied : nvm_control_reg; // RULE_05
    wire go_next = go_ok || (nvm_control_reg[cmm_pkg::NVM_GO_BIT] && !run_done);
    wire [7:0] next_nvm = (nvm_soft & ~go_mask) | (go_next ? go_mask : 8'h00); // RULE_07

    // Table pointer: byte moves from the working register, or step after a load
    wire sel_upper = is_movwf && (pay_lo == cmm_pkg::SFR_PTR_UPPER);
    wire sel_high = is_movwf && (pay_lo == cmm_pkg::SFR_PTR_HIGH);
    wire sel_low = is_movwf && (pay_lo == cmm_pkg::SFR_PTR_LOW);
    wire [21:0] ptr_step = tblptr + cmm_pkg::PTR_STEP;
    wire [21:0] next_ptr =
        sel_upper ? {w_reg[5:0], tblptr[15:0]} :
        sel_high ? {tblptr[21:16], w_reg, tblptr[7:0]} :
        sel_low ? {tblptr[21:8], w_reg} :
        is_load ? ptr_step : tblptr; // RULE_06 RULE_09
    wire [7:0] next_w = is_movlw ? pay_lo : w_reg; // RULE_18

    // Operation sequence: armed by cycle-go or a start command, runs while the held pulse is high
    always_comb
    begin
        next_state = state;
        unique case (state)
            cmm_pkg::ST_IDLE:
                if (run_start)
                    next_state = cmm_pkg::ST_ARMED;
            cmm_pkg::ST_ARMED:
                if (hold_s2 && sclk_s2)
                    next_state = cmm_pkg::ST_RUN; // RULE_16
            cmm_pkg::ST_RUN:
                if (!sclk_s2)
                    next_state = cmm_pkg::ST_IDLE; // RULE_08
        endcase
    end

    // Erase when go finds row-erase select set, otherwise program the buffer
    wire next_op_erase = go_ok ? nvm_control_reg[cmm_pkg::NVM_ROW_ERASE_BIT]
                               : (is_start && idle) ? 1'h0 : op_erase; // RULE_03
    wire next_run = next_state == cmm_pkg::ST_RUN;

    // AHB-Lite slave: zero wait states, always OKAY
    wire ahb_take = hsel && hready && htrans[1];
    wire ctrl_wr = wr_pend && (wr_addr == cmm_pkg::OFS_CTRL);
    wire status_wr = wr_pend && (wr_addr == cmm_pkg::OFS_STATUS);
    wire refused_clr = status_wr && hwdata[cmm_pkg::STAT_REFUSED_BIT];
    // Set wins over a simultaneous clear so no refusal is lost
    wire next_refused = go_refused || (refused && !refused_clr);
    wire next_enable = ctrl_wr ? hwdata[cmm_pkg::CTRL_ENABLE_BIT] : enable;
    wire [31:0] rd_status = {22'h000000, refused, !idle, nvm_control_reg};
    wire [31:0] rd_mux =
        (haddr == cmm_pkg::OFS_CTRL) ? {31'h00000000, enable} :
        (haddr == cmm_pkg::OFS_STATUS) ? rd_status :
        (haddr == cmm_pkg::OFS_TBLPTR) ? {10'h000, tblptr} :
        (haddr == cmm_pkg::OFS_WREG) ? {24'h000000, w_reg} : 32'h00000000;

    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    // Read-back and shift-out are outside this block, so the pin is never driven
    assign prog_serial_data_out = 1'h0;
    assign prog_serial_data_oe = 1'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'h0;
            wr_addr <= 32'h00000000;
            hrdata <= 32'h00000000;
        end
        else
        begin
            wr_pend <= ahb_take && hwrite;
            wr_addr <= haddr;
            if (ahb_take && !hwrite)
                hrdata <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enable <= cmm_pkg::CTRL_ENABLE_RST;
            refused <= 1'h0;
            nvm_control_reg <= cmm_pkg::NVM_CTRL_RST;
            w_reg <= cmm_pkg::WREG_RST;
            tblptr <= cmm_pkg::PTR_RST;
        end
        else
        begin
            enable <= next_enable;
            refused <= next_refused;
            nvm_control_reg <= next_nvm;
            w_reg <= next_w;
            tblptr <= next_ptr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= cmm_pkg::ST_IDLE;
            op_erase <= 1'h0;
            flash_erase <= 1'h0;
            flash_program <= 1'h0;
            flash_addr <= cmm_pkg::PTR_RST;
        end
        else
        begin
            state <= next_state;
            op_erase <= next_op_erase;
            flash_erase <= next_run && next_op_erase; // RULE_08
            flash_program <= next_run && !next_op_erase; // RULE_12
            flash_addr <= next_ptr;
        end
    end

    // Write buffer: payload high byte is the odd address, low byte the even
    always_ff @(posedge hclk)
    begin
        if (buf_fill)
        begin
            wbuf[idx_even] <= pay_lo; // RULE_10
            wbuf[idx_odd] <= pay_hi; // RULE_09
        end
        flash_buf_rdata <= wbuf[flash_buf_raddr];
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_GO_NEEDS_UNLOCK: assert property ( // RULE_04
        set_go && !unlocked |=> refused && !nvm_control_reg[cmm_pkg::NVM_GO_BIT]
            && state == cmm_pkg::ST_IDLE)
        else $error("cycle-go accepted without unlock");

    AST_ERASE_ARMS: assert property ( // RULE_03
        go_ok && nvm_control_reg[cmm_pkg::NVM_ROW_ERASE_BIT]
            |=> op_erase && state == cmm_pkg::ST_ARMED)
        else $error("erase not armed after cycle-go");

    AST_LOAD_STEP: assert property ( // RULE_09
        is_load |=> tblptr == $past(tblptr) + cmm_pkg::PTR_STEP)
        else $error("table pointer not advanced by two");

    AST_BUF_PLACE: assert property ( // RULE_10
        buf_fill |=> wbuf[$past(idx_even)] == $past(pay_lo)
            && wbuf[$past(idx_odd)] == $past(pay_hi))
        else $error("buffer bytes misplaced");

    AST_START_PROG: assert property ( // RULE_12
        is_start && idle |=> state == cmm_pkg::ST_ARMED && !op_erase)
        else $error("start command did not arm programming");

    AST_PTR_LOW: assert property ( // RULE_06
        sel_low |=> tblptr[7:0] == $past(w_reg) && $stable(tblptr[21:8]))
        else $error("table pointer low byte not loaded");

    AST_UNLOCK_SET: assert property ( // RULE_07
        is_bitop && is_bsf && pay_hi[3:1] == 3'h2 |=> nvm_control_reg[cmm_pkg::NVM_UNLOCK_BIT])
        else $error("unlock bit not set");

    AST_RUN_HELD: assert property ( // RULE_16
        $rose(flash_program || flash_erase) |-> $past(hold_s2) && $past(sclk_s2))
        else $error("run began without the held fourth pulse");

    AST_RUN_ENDS: assert property ( // RULE_08
        state == cmm_pkg::ST_RUN && !sclk_s2
            |=> !flash_program && !flash_erase ##1 !nvm_control_reg[cmm_pkg::NVM_GO_BIT])
        else $error("run did not end when the clock fell");

    AST_ONE_EXEC: assert property ( // RULE_18
        is_movlw |=> w_reg == $past(pay_lo) ##1 !exec)
        else $error("core instruction not executed once");

    AST_PTR_UPPER: assert property ( // RULE_06
        sel_upper |=> tblptr[21:16] == $past(w_reg[5:0]) && $stable(tblptr[15:0]))
        else $error("table pointer upper byte not loaded");

    AST_PTR_HIGH: assert property ( // RULE_06
        sel_high |=> tblptr[15:8] == $past(w_reg)
            && $stable(tblptr[21:16]) && $stable(tblptr[7:0]))
        else $error("table pointer high byte not loaded");

    AST_START_KEEPS_PTR: assert property ( // RULE_12
        is_start |=> $stable(tblptr))
        else $error("start command moved the table pointer");

    AST_UNLOCK_CLEAR: assert property ( // RULE_07
        is_bitop && is_bcf && pay_hi[3:1] == 3'h2 |=> !unlocked)
        else $error("unlock bit not cleared");

    AST_ERASE_UNLOCKED: assert property ( // RULE_04
        $rose(flash_erase) |-> unlocked)
        else $error("erase ran without unlock");

    AST_GO_BUSY_REFUSED: assert property ( // RULE_04
        set_go && !idle |=> refused && $stable(op_erase))
        else $error("cycle-go accepted while busy");

    AST_BUF_FROM_PTR: assert property ( // RULE_10
        buf_fill |=> wbuf[{$past(tblptr[5:1]), 1'h0}] == $past(pay_lo))
        else $error("buffer byte not at the table pointer");

    AST_REFUSED_HOLDS: assert property ( // RULE_04
        refused && !refused_clr |=> refused)
        else $error("refusal flag lost without a clear");
endmodule : cmm_seq

// ### tb/cmm_prog_model.sv
// Programmer model: drives the serial link clock and data line
`timescale 1ns/1ns
module cmm_prog_model (
    output logic prog_serial_clock,
    output logic prog_serial_data
);
    localparam int HALF_NS = 24;
    localparam int DISCHARGE_NS = 1000;

    initial
    begin
        prog_serial_clock = 1'h0;
        prog_serial_data = 1'h0;
    end

    // Clock idles low between frames; data flips so a stale bit never looks valid
    task automatic send_frame(input logic [3:0] cmd, input logic [15:0] pl, input int hold_ns);
        logic [19:0] word;
        word = {pl, cmd};
        for (int i = 0; i < 20; i++)
        begin
            prog_serial_data = word[i];
            #HALF_NS prog_serial_clock = 1'h1;
            if (i == 3)
            begin
                #hold_ns;
            end
            #HALF_NS prog_serial_clock = 1'h0;
            // Discharge follows the held pulse at once, before the rest of the frame
            if (i == 3 && hold_ns > 0)
            begin
                #DISCHARGE_NS;
            end
        end
        prog_serial_data = ~prog_serial_data;
    endtask : send_frame
endmodule : cmm_prog_model

// ### tb/tb_top.sv
// Testbench: drives the sequencer over AHB-Lite and the serial link
`timescale 1ns/1ns
module tb_top;
    typedef struct {logic [3:0] cmd; logic [15:0] pl;
                    logic [31:0] addr; logic [31:0] exp;} cmm_row_t;
    localparam int HOLD_NS = 2000;
    logic hclk, hresetn, hwrite, hreadyout, hresp, prog_serial_clock, prog_drv;
    logic prog_serial_data_out, prog_serial_data_oe, flash_erase, flash_program;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [21:0] flash_addr;
    logic [5:0] flash_buf_raddr;
    logic [7:0] flash_buf_rdata;
    logic [31:0] erase_cnt = 32'h0;
    logic [31:0] program_cnt = 32'h0;
    logic [31:0] e0, p0;
    logic [21:0] erase_addr;
    wire hready = hreadyout;
    wire sd_wire = prog_serial_data_oe ? prog_serial_data_out : prog_drv;
    int fail_count = 0;
    int n_compared = 0;
    cmm_row_t rows [12] = '{
        '{cmm_pkg::CMD_CORE, 16'h0E3F, cmm_pkg::OFS_WREG, 32'h0000003F},
        '{cmm_pkg::CMD_CORE, 16'h6EF8, cmm_pkg::OFS_TBLPTR, 32'h003F0000},
        '{cmm_pkg::CMD_CORE, 16'h0E12, cmm_pkg::OFS_WREG, 32'h00000012},
        '{cmm_pkg::CMD_CORE, 16'h6EF7, cmm_pkg::OFS_TBLPTR, 32'h003F1200},
        '{cmm_pkg::CMD_CORE, 16'h0E3C, cmm_pkg::OFS_WREG, 32'h0000003C},
        '{cmm_pkg::CMD_CORE, 16'h6EF6, cmm_pkg::OFS_TBLPTR, 32'h003F123C},
        '{cmm_pkg::CMD_CORE, 16'h8EA6, cmm_pkg::OFS_STATUS, 32'h00000080},
        '{cmm_pkg::CMD_CORE, 16'h8CA6, cmm_pkg::OFS_STATUS, 32'h000000C0},
        '{cmm_pkg::CMD_CORE, 16'h9CA6, cmm_pkg::OFS_STATUS, 32'h00000080},
        '{cmm_pkg::CMD_LOAD, 16'hBBAA, cmm_pkg::OFS_TBLPTR, 32'h003F123E},
        '{cmm_pkg::CMD_LOAD, 16'hDDCC, cmm_pkg::OFS_TBLPTR, 32'h003F1240},
        '{4'h2, 16'h1234, cmm_pkg::OFS_TBLPTR, 32'h003F1240}
    };
    logic [5:0] bidx [6] = '{6'h3C, 6'h3D, 6'h3E, 6'h3F, 6'h00, 6'h01};
    logic [7:0] bexp [6] = '{8'hAA, 8'hBB, 8'hCC, 8'hDD, 8'h11, 8'h22};
    logic [31:0] rst_exp [4] = '{32'h00000001, 32'h00000000, 32'h00000000, 32'h00000000};

    cmm_seq cmm_seq_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .prog_serial_clock(prog_serial_clock), .prog_serial_data_in(sd_wire),
        .prog_serial_data_out(prog_serial_data_out), .prog_serial_data_oe(prog_serial_data_oe),
        .flash_erase(flash_erase), .flash_program(flash_program), .flash_addr(flash_addr),
        .flash_buf_raddr(flash_buf_raddr), .flash_buf_rdata(flash_buf_rdata)
    );

    cmm_prog_model cmm_prog_model_inst (
        .prog_serial_clock(prog_serial_clock),
        .prog_serial_data(prog_drv)
    );

    initial
    begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end

    // Counting cycles catches a pulse that a single sample could miss
    always @(posedge hclk)
    begin
        if (flash_erase === 1'b1)
        begin
            erase_cnt <= erase_cnt + 32'h1;
            erase_addr <= flash_addr;
        end
        if (flash_program === 1'b1)
        begin
            program_cnt <= program_cnt + 32'h1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic frame(input logic [3:0] c, input logic [15:0] p, input int h);
        cmm_prog_model_inst.send_frame(c, p, h);
        repeat (6) @(posedge hclk);
    endtask : frame

    initial
    begin
        #500000;
        fail_count++;
        print_verdict();
    end

    initial
    begin
        hresetn = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        flash_buf_raddr = 6'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            bus(32'(i * 4), 1'h0, 32'h0, v);
            check(v, rst_exp[i]);
        end
        for (int i = 0; i < 12; i++)
        begin
            frame(rows[i].cmd, rows[i].pl, 0);
            bus(rows[i].addr, 1'h0, 32'h0, v);
            check(v, rows[i].exp);
        end
        // Go without unlock must not erase
        e0 = erase_cnt;
        frame(cmm_pkg::CMD_CORE, 16'h82A6, 0);
        frame(cmm_pkg::CMD_CORE, 16'h0000, HOLD_NS);
        check(erase_cnt - e0, 32'h0);
        bus(cmm_pkg::OFS_STATUS, 1'h0, 32'h0, v);
        check(32'(v[9]), 32'h1);
        bus(cmm_pkg::OFS_STATUS, 1'h1, 32'h00000200, v);
        bus(cmm_pkg::OFS_STATUS, 1'h0, 32'h0, v);
        check(32'(v[9]), 32'h0);
        // Unlock, row erase select, go, then timed no-op
        frame(cmm_pkg::CMD_CORE, 16'h84A6, 0);
        bus(cmm_pkg::OFS_STATUS, 1'h0, 32'h0, v);
        check(32'(v[7:0]), 32'h84);
        frame(cmm_pkg::CMD_CORE, 16'h88A6, 0);
        frame(cmm_pkg::CMD_CORE, 16'h82A6, 0);
        bus(cmm_pkg::OFS_STATUS, 1'h0, 32'h0, v);
        check(32'(v[8:0]), 32'h196);
        e0 = erase_cnt;
        p0 = program_cnt;
        frame(cmm_pkg::CMD_CORE, 16'h0000, HOLD_NS);
        check(32'(erase_cnt - e0 >= 12 && erase_cnt - e0 <= 28), 32'h1);
        check(program_cnt - p0, 32'h0);
        check(32'(erase_addr), 32'h003F1240);
        bus(cmm_pkg::OFS_STATUS, 1'h0, 32'h0, v);
        check(32'(v[8:0]), 32'h094);
        // Last two bytes and start, pointer must not advance
        frame(cmm_pkg::CMD_START, 16'h2211, 0);
        bus(cmm_pkg::OFS_STATUS, 1'h0, 32'h0, v);
        check(32'(v[8]), 32'h1);
        bus(cmm_pkg::OFS_TBLPTR, 1'h0, 32'h0, v);
        check(v, 32'h003F1240);
        e0 = erase_cnt;
        p0 = program_cnt;
        frame(cmm_pkg::CMD_CORE, 16'h0000, HOLD_NS);
        check(32'(program_cnt - p0 >= 12 && program_cnt - p0 <= 28), 32'h1);
        check(erase_cnt - e0, 32'h0);
        check(32'(flash_program), 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            flash_buf_raddr <= bidx[i];
            repeat (2) @(posedge hclk);
            check(32'(flash_buf_rdata), 32'(bexp[i]));
        end
        frame(cmm_pkg::CMD_CORE, 16'h94A6, 0);
        bus(cmm_pkg::OFS_STATUS, 1'h0, 32'h0, v);
        check(32'(v[7:0]), 32'h90);
        // Next block: pointer stepped by one erase block, erased the same way
        frame(cmm_pkg::CMD_CORE, 16'h0E80, 0);
        frame(cmm_pkg::CMD_CORE, 16'h6EF6, 0);
        frame(cmm_pkg::CMD_CORE, 16'h84A6, 0);
        frame(cmm_pkg::CMD_CORE, 16'h82A6, 0);
        e0 = erase_cnt;
        frame(cmm_pkg::CMD_CORE, 16'h0000, HOLD_NS);
        check(32'(erase_cnt - e0 >= 12 && erase_cnt - e0 <= 28), 32'h1);
        check(32'(erase_addr), 32'h003F1280);
        frame(cmm_pkg::CMD_CORE, 16'h94A6, 0);
        // Disabled link drops frames; unmapped place reads zero
        bus(cmm_pkg::OFS_CTRL, 1'h1, 32'h0, v);
        frame(cmm_pkg::CMD_CORE, 16'h0E55, 0);
        bus(cmm_pkg::OFS_WREG, 1'h0, 32'h0, v);
        check(v, 32'h00000080);
        bus(cmm_pkg::OFS_CTRL, 1'h1, 32'h00000001, v);
        bus(32'h00000010, 1'h0, 32'h0, v);
        check(v, 32'h0);
        // Reset while idle clears the sequencer; outputs go low except hreadyout, which stays high, and flash_buf_rdata, which is not reset
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        check(32'({hreadyout, hresp, prog_serial_data_oe, prog_serial_data_out}), 32'h8);
        check(32'({flash_erase, flash_program}), 32'h0);
        check(hrdata, 32'h0);
        hresetn <= 1'h1;
        bus(cmm_pkg::OFS_TBLPTR, 1'h0, 32'h0, v);
        check(v, 32'h0);
        bus(cmm_pkg::OFS_STATUS, 1'h0, 32'h0, v);
        check(v, 32'h0);
        print_verdict();
    end
endmodule : tb_top
